// ### include/port1_defs.vh
`ifndef PORT1_DEFS_VH
`define PORT1_DEFS_VH

// Register addresses, lower 20 bits of the advanced-mode address
`define ADDR_W            20
`define PORT_DIR_ADDR     20'hee000
`define PORT_LATCH_ADDR   20'hfffd0

// Port geometry
`define PORT_W            8
`define MODE_W            3

// Operating mode codes as strapped on the mode pins
`define MODE_EXP_FIRST    3'h1
`define MODE_EXP_LAST     3'h4
`define MODE_EXP_ROM      3'h5
`define MODE_SINGLE_A     3'h6
`define MODE_SINGLE_B     3'h7

// Initial values and fixed read values
`define DIR_INIT_EXP      8'hff
`define DIR_INIT_OTHER    8'h00
`define LATCH_INIT        8'h00
`define DIR_READ_VALUE    8'hff
`define UNMAPPED_READ     8'h00
`define RDATA_IDLE        8'h00

// Life-cycle state codes
`define LC_W              2
`define LC_INIT           2'h0
`define LC_RUN            2'h1
`define LC_HW_STBY        2'h2
`define LC_SW_STBY        2'h3

`endif

// ### hw/byte_reg.v
`timescale 1ns/1ps
// Storage byte with constant async reset, sync initialise and write
module byte_reg #(
	parameter             WIDTH     = 8,
	parameter [WIDTH-1:0] RESET_VAL = {WIDTH{1'b0}}
) (
	input  wire             core_clk,
	input  wire             rstn,
	input  wire             init_en,
	input  wire [WIDTH-1:0] init_val,
	input  wire             wr_en,
	input  wire [WIDTH-1:0] wr_data,
	output wire [WIDTH-1:0] q
);

	reg [WIDTH-1:0] value_reg;
	reg [WIDTH-1:0] value_next;

	// Initialise beats a write so standby entry cannot be undone by software
	always @* begin
		value_next = value_reg;
		if (init_en) begin
			value_next = init_val;
		end else if (wr_en) begin
			value_next = wr_data;
		end
	end

	// Async reset takes only the constant; mode-dependent values load later
	always @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			value_reg <= RESET_VAL;
		end else begin
			value_reg <= value_next;
		end
	end

	assign q = value_reg;

endmodule

// ### hw/port_pin_cell.v
`timescale 1ns/1ps
// One port pin: chooses address or latch drive and the output enable
module port_pin_cell (
	input  wire core_clk,
	input  wire rstn,
	input  wire drive_en,
	input  wire addr_sel,
	input  wire addr_bit,
	input  wire latch_bit,
	input  wire dir_bit,
	input  wire pin_in,
	output reg  pin_out,
	output reg  pin_oe_n,
	output wire read_bit
);

	// Pin stage is registered so the pad sees no decode glitches
	always @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			pin_out  <= 1'b0;
			pin_oe_n <= 1'b1;
		end else begin
			pin_out  <= addr_sel ? addr_bit : latch_bit;
			pin_oe_n <= ~drive_en;
		end
	end

	// Input pins read the live level, output pins read back the latch
	assign read_bit = dir_bit ? latch_bit : pin_in;

endmodule

// ### hw/port1_address_gpio.v
// The address-and-strobe port was left to the implementer.
`timescale 1ns/1ps
`include "port1_defs.vh"
// Overview of operation
// - Modes 1-4: all pins drive address out
// - Mode 5: direction one address, zero input
// - Mode 5 after reset: all pins input
// - Modes 6-7: direction selects output or input
// - Modes 1-4: direction reads ones, writes ignored
// - Modes 5-7: direction write-only, reads ones
// - Reset/hardware standby: direction FF or 00
// - Software standby keeps direction and output drive
// - Modes 6-7: output pins drive output latch bits
// - Data read: pin if input, latch if output
// - Latch clears on reset/hardware standby, holds otherwise
// - Registers decode at their fixed addresses
module port1_address_gpio (
	input  wire                 core_clk,
	input  wire                 rstn,
	input  wire [`MODE_W-1:0]   mode_pins,
	input  wire                 hw_standby,
	input  wire                 sw_standby,
	input  wire [`PORT_W-1:0]   bus_addr,
	input  wire [`ADDR_W-1:0]   reg_addr,
	input  wire [`PORT_W-1:0]   reg_wdata,
	input  wire                 reg_wr,
	input  wire                 reg_rd,
	output reg  [`PORT_W-1:0]   reg_rdata,
	input  wire [`PORT_W-1:0]   pin_in,
	output wire [`PORT_W-1:0]   pin_out,
	output wire [`PORT_W-1:0]   pin_oe_n,
	output reg  [`PORT_W-1:0]   addr_pin_mask,
	output reg  [`LC_W-1:0]     port_state
);

	localparam [`LC_W-1:0] LC_INIT    = `LC_INIT;
	localparam [`LC_W-1:0] LC_RUN     = `LC_RUN;
	localparam [`LC_W-1:0] LC_HW_STBY = `LC_HW_STBY;
	localparam [`LC_W-1:0] LC_SW_STBY = `LC_SW_STBY;

	reg  [`MODE_W-1:0] mode_reg;
	reg  [`LC_W-1:0]   state_next;
	reg                mode_expanded;
	reg                mode_rom;
	reg                mode_single;
	reg                sel_dir;
	reg                sel_latch;
	reg                access_ok;
	reg  [`PORT_W-1:0] dir_init;
	reg  [`PORT_W-1:0] dir_eff;
	reg  [`PORT_W-1:0] drive_mask;
	reg  [`PORT_W-1:0] addr_mask;
	reg  [`PORT_W-1:0] rdata_next;
	wire               regs_init;
	wire               dir_wr;
	wire               latch_wr;
	wire [`PORT_W-1:0] dir_q;
	wire [`PORT_W-1:0] latch_q;
	wire [`PORT_W-1:0] read_bits;

	// Mode pins are a strap: caught by the clock while initialising,
	// never by the async reset, so a floating level cannot leak in
	always @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			mode_reg <= {`MODE_W{1'b0}};
		end else if (port_state == LC_INIT) begin
			mode_reg <= mode_pins;
		end
	end

	// Decode of the captured mode into the three port personalities
	always @* begin
		mode_expanded = (mode_reg >= `MODE_EXP_FIRST) && (mode_reg <= `MODE_EXP_LAST);
		mode_rom      = (mode_reg == `MODE_EXP_ROM);
		mode_single   = (mode_reg == `MODE_SINGLE_A) || (mode_reg == `MODE_SINGLE_B);
	end

	// Life cycle: one init cycle after reset, then run or standby.
	// Hardware standby wins over software standby since it reinitialises.
	always @* begin
		case (port_state)
			LC_INIT: begin
				state_next = LC_RUN;
			end
			LC_RUN: begin
				if (hw_standby) begin
					state_next = LC_HW_STBY;
				end else if (sw_standby) begin
					state_next = LC_SW_STBY;
				end else begin
					state_next = LC_RUN;
				end
			end
			LC_HW_STBY: begin
				state_next = hw_standby ? LC_HW_STBY : LC_RUN;
			end
			LC_SW_STBY: begin
				if (hw_standby) begin
					state_next = LC_HW_STBY;
				end else if (sw_standby) begin
					state_next = LC_SW_STBY;
				end else begin
					state_next = LC_RUN;
				end
			end
			default: begin
				state_next = LC_INIT;
			end
		endcase
	end

	always @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			port_state <= LC_INIT;
		end else begin
			port_state <= state_next;
		end
	end

	// Registers reload their initial values in the init cycle and
	// throughout hardware standby; software standby leaves them alone
	assign regs_init = (port_state == LC_INIT) || (port_state == LC_HW_STBY) || hw_standby;

	// Direction initial value follows the mode being captured; in the
	// init cycle mode_reg is not yet valid, so decode the pins directly
	always @* begin
		if (port_state == LC_INIT) begin
			if ((mode_pins >= `MODE_EXP_FIRST) && (mode_pins <= `MODE_EXP_LAST)) begin
				dir_init = `DIR_INIT_EXP;
			end else begin
				dir_init = `DIR_INIT_OTHER;
			end
		end else begin
			dir_init = mode_expanded ? `DIR_INIT_EXP : `DIR_INIT_OTHER;
		end
	end

	// Register address decode; accesses are only honoured while running,
	// since the CPU cannot issue cycles in either standby
	always @* begin
		sel_dir   = (reg_addr == `PORT_DIR_ADDR);
		sel_latch = (reg_addr == `PORT_LATCH_ADDR);
		access_ok = (port_state == LC_RUN) && !hw_standby;
	end

	// Writes to direction are dropped in modes 1-4
	assign dir_wr   = reg_wr && sel_dir && access_ok && !mode_expanded;
	assign latch_wr = reg_wr && sel_latch && access_ok;

	// Direction register; held through software standby
	byte_reg #(
		.WIDTH     (`PORT_W),
		.RESET_VAL (`DIR_INIT_OTHER)
	) u_port_direction (
		.core_clk (core_clk),
		.rstn     (rstn),
		.init_en  (regs_init),
		.init_val (dir_init),
		.wr_en    (dir_wr),
		.wr_data  (reg_wdata),
		.q        (dir_q)
	);

	// Output latch; clears on reset and hardware standby only
	byte_reg #(
		.WIDTH     (`PORT_W),
		.RESET_VAL (`LATCH_INIT)
	) u_port_output_latch (
		.core_clk (core_clk),
		.rstn     (rstn),
		.init_en  (regs_init),
		.init_val (`LATCH_INIT),
		.wr_en    (latch_wr),
		.wr_data  (reg_wdata),
		.q        (latch_q)
	);

	// Effective direction and pin roles per mode.  In modes 1-4 the
	// stored value is bypassed so a stray state can never turn an
	// address line into an input.
	always @* begin
		dir_eff    = dir_q;
		drive_mask = {`PORT_W{1'b0}};
		addr_mask  = {`PORT_W{1'b0}};
		if (mode_expanded) begin
			dir_eff    = `DIR_INIT_EXP;
			drive_mask = {`PORT_W{1'b1}};
			addr_mask  = {`PORT_W{1'b1}};
		end else if (mode_rom) begin
			drive_mask = dir_q;
			addr_mask  = dir_q;
		end else if (mode_single) begin
			drive_mask = dir_q;
		end
		// Nothing drives until the mode is known or in hardware standby
		if ((port_state == LC_INIT) || (port_state == LC_HW_STBY) || hw_standby) begin
			drive_mask = {`PORT_W{1'b0}};
			addr_mask  = {`PORT_W{1'b0}};
		end
	end

	// One cell per pin; software standby keeps the drive state intact
	genvar i;
	generate
		for (i = 0; i < `PORT_W; i = i + 1) begin : g_pin
			port_pin_cell u_cell (
				.core_clk  (core_clk),
				.rstn      (rstn),
				.drive_en  (drive_mask[i]),
				.addr_sel  (addr_mask[i]),
				.addr_bit  (bus_addr[i]),
				.latch_bit (latch_q[i]),
				.dir_bit   (dir_eff[i]),
				.pin_in    (pin_in[i]),
				.pin_out   (pin_out[i]),
				.pin_oe_n  (pin_oe_n[i]),
				.read_bit  (read_bits[i])
			);
		end
	endgenerate

	// Read mux; direction is never readable, it always shows all ones
	always @* begin
		rdata_next = `UNMAPPED_READ;
		if (sel_dir) begin
			rdata_next = `DIR_READ_VALUE;
		end else if (sel_latch) begin
			rdata_next = read_bits;
		end
	end

	// Read data stand only in the cycle after the strobe, zero otherwise
	always @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			reg_rdata <= `RDATA_IDLE;
		end else if (reg_rd && access_ok) begin
			reg_rdata <= rdata_next;
		end else begin
			reg_rdata <= `RDATA_IDLE;
		end
	end

	// Status: which pins are currently address lines, aligned with pins
	always @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			addr_pin_mask <= {`PORT_W{1'b0}};
		end else begin
			addr_pin_mask <= addr_mask & drive_mask;
		end
	end

endmodule

// ### dv/port1_address_gpio_assertions.sv
`timescale 1ns/1ps
`include "port1_defs.vh"
// Watches register answers and pin drive at the port's boundary
module port1_checker (
	input wire                core_clk,
	input wire                rstn,
	input wire                hw_standby,
	input wire                sw_standby,
	input wire [`PORT_W-1:0]  bus_addr,
	input wire [`ADDR_W-1:0]  reg_addr,
	input wire                reg_wr,
	input wire                reg_rd,
	input wire [`PORT_W-1:0]  reg_rdata,
	input wire [`PORT_W-1:0]  pin_in,
	input wire [`PORT_W-1:0]  pin_out,
	input wire [`PORT_W-1:0]  pin_oe_n,
	input wire [`PORT_W-1:0]  addr_pin_mask,
	input wire [`LC_W-1:0]    port_state
);
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!rstn);
	// A read only counts while running and awake
	wire rd_ok = reg_rd && port_state == `LC_RUN && !hw_standby && !sw_standby;
	wire rd_lat = rd_ok && reg_addr == `PORT_LATCH_ADDR && !reg_wr;
	a_rdata_idle: assert property (!reg_rd |=> reg_rdata == 8'h00)
		else $error("read data not idle");
	a_dir_ones: assert property (rd_ok && reg_addr == `PORT_DIR_ADDR |=> reg_rdata == 8'hff)
		else $error("direction read not all ones");
	a_unmapped_zero: assert property (rd_ok && reg_addr != `PORT_DIR_ADDR
		&& reg_addr != `PORT_LATCH_ADDR |=> reg_rdata == 8'h00)
		else $error("unmapped read not zero");
	// Input bits read the live pin; a write just before could move the direction
	a_input_read: assert property (rd_lat && !$past(reg_wr)
		|=> ((reg_rdata ^ $past(pin_in)) & $past(pin_oe_n)) == 8'h00)
		else $error("input bit read wrong");
	a_output_read: assert property (rd_lat && !$past(reg_wr)
		|=> ((reg_rdata ^ $past(pin_out)) & ~$past(pin_oe_n | addr_pin_mask)) == 8'h00)
		else $error("output bit read wrong");
	a_addr_follow: assert property (addr_pin_mask != 8'h00
		|-> ((pin_out ^ $past(bus_addr)) & addr_pin_mask) == 8'h00)
		else $error("address pin wrong");
	a_mask_drive: assert property (##1 (addr_pin_mask & pin_oe_n) == 8'h00)
		else $error("address pin not driven");
	a_hw_inputs: assert property (hw_standby ##1 hw_standby |=> pin_oe_n == 8'hff)
		else $error("pin driven in hardware standby");
	a_sw_hold: assert property (sw_standby ##1 sw_standby |=> $stable(pin_oe_n))
		else $error("drive changed in software standby");
	c_lat_read: cover property (rd_lat);
	c_sw_stby: cover property (sw_standby ##1 sw_standby);
	c_all_addr: cover property (addr_pin_mask == 8'hff);
endmodule

// ### dv/pin_partner.sv
`timescale 1ns/1ps
// Peripheral on the far side; it drives every pin the port leaves free
module pin_partner (
	input  wire [7:0] pin_out,
	input  wire [7:0] pin_oe_n,
	input  wire [7:0] ext_val,
	output wire [7:0] pin_in
);
	// Wire level: the port wins where it drives, else the peripheral
	assign pin_in = (pin_out & ~pin_oe_n) | (ext_val & pin_oe_n);
endmodule

// ### dv/testbench.sv
`timescale 1ns/1ps
`include "port1_defs.vh"
module testbench;
	logic        core_clk, rstn, hw_standby, sw_standby, reg_wr, reg_rd;
	logic [2:0]  mode_pins;
	logic [7:0]  bus_addr, reg_wdata, ext_val, dir, lat, r;
	logic [19:0] reg_addr;
	logic [31:0] seed;
	wire  [7:0]  reg_rdata, pin_in, pin_out, pin_oe_n, addr_pin_mask;
	wire  [1:0]  port_state;
	int          err_total, num_checks;
	port1_address_gpio uut (.core_clk(core_clk), .rstn(rstn), .mode_pins(mode_pins),
		.hw_standby(hw_standby), .sw_standby(sw_standby), .bus_addr(bus_addr),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.reg_rdata(reg_rdata), .pin_in(pin_in), .pin_out(pin_out), .pin_oe_n(pin_oe_n),
		.addr_pin_mask(addr_pin_mask), .port_state(port_state));
	pin_partner far (.pin_out(pin_out), .pin_oe_n(pin_oe_n), .ext_val(ext_val), .pin_in(pin_in));
	initial begin
		core_clk = 1'b0;
		forever #10 core_clk = ~core_clk;
	end
	function automatic logic [7:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed[7:0];
	endfunction
	task automatic chk(string n, logic [7:0] e, logic [7:0] g);
		num_checks++;
		if (g !== e) begin
			$display("ERROR %s expected %h seen %h", n, e, g);
			err_total++;
		end
	endtask
	task automatic cyc(int n);
		repeat (n) @(posedge core_clk);
	endtask
	task automatic wr(logic [19:0] a, logic [7:0] d);
		@(posedge core_clk);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge core_clk);
		reg_wr <= 1'b0;
	endtask
	task automatic rd(logic [19:0] a, string n, logic [7:0] e);
		@(posedge core_clk);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge core_clk);
		reg_rd <= 1'b0;
		#1 chk(n, e, reg_rdata);
	endtask
	// Model: direction stays all ones in expanded modes, so ~dir is the drive
	task automatic pins(string n);
		chk({n, " oe"}, ~dir, pin_oe_n);
		chk({n, " out"}, (mode_pins <= 5 ? bus_addr : lat) & dir, pin_out & ~pin_oe_n);
		chk({n, " mask"}, (mode_pins <= 3'h5) ? dir : 8'h00, addr_pin_mask);
	endtask
	task automatic complete_run;
		$display("checks %0d errors %0d", num_checks, err_total);
		if (err_total == 0 && num_checks > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask
	// Watchdog so that a stuck sequence still reaches the verdict
	initial begin
		cyc(3000);
		err_total++;
		complete_run;
	end
	initial begin
		{rstn, hw_standby, sw_standby, reg_wr, reg_rd} = 5'h00;
		{reg_addr, reg_wdata, mode_pins} = 31'h0;
		seed = 32'hf2c6;
		bus_addr = rnd();
		ext_val = rnd();
		for (int m = 1; m < 8; m++) begin
			rstn <= 1'b0;
			mode_pins <= m[2:0];
			cyc(6);
			rstn <= 1'b1;
			dir = (m < 5) ? 8'hff : 8'h00;
			lat = 8'h00;
			cyc(2);
			rd(`PORT_DIR_ADDR, "dir", 8'hff);
			rd(`PORT_LATCH_ADDR, "lat rst", (lat & dir) | (ext_val & ~dir));
			pins("rst");
			r = rnd();
			wr(`PORT_DIR_ADDR, r);
			if (m >= 5) dir = r;
			lat = rnd();
			wr(`PORT_LATCH_ADDR, lat);
			wr(20'h00fff, rnd());
			rd(20'h00fff, "unmapped", 8'h00);
			// New bus address and far-side level, launched on a rising edge
			@(posedge core_clk);
			bus_addr <= rnd();
			ext_val <= rnd();
			cyc(1);
			#1 pins("run");
			rd(`PORT_LATCH_ADDR, "lat run", (lat & dir) | (ext_val & ~dir));
			sw_standby <= 1'b1;
			cyc(3);
			// A write while asleep must not reach the latch
			wr(`PORT_LATCH_ADDR, ~lat);
			#1 pins("sw");
			chk("sw state", `LC_SW_STBY, port_state);
			sw_standby <= 1'b0;
			cyc(2);
			rd(`PORT_LATCH_ADDR, "lat sw", (lat & dir) | (ext_val & ~dir));
			hw_standby <= 1'b1;
			cyc(3);
			#1 chk("hw oe", 8'hff, pin_oe_n);
			chk("hw state", `LC_HW_STBY, port_state);
			hw_standby <= 1'b0;
			dir = (m < 5) ? 8'hff : 8'h00;
			lat = 8'h00;
			cyc(3);
			rd(`PORT_LATCH_ADDR, "lat hw", (lat & dir) | (ext_val & ~dir));
			pins("hw");
		end
		complete_run;
	end
endmodule
bind port1_address_gpio port1_checker chk_i (.core_clk(core_clk), .rstn(rstn),
	.hw_standby(hw_standby), .sw_standby(sw_standby), .bus_addr(bus_addr),
	.reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
	.pin_in(pin_in), .pin_out(pin_out), .pin_oe_n(pin_oe_n),
	.addr_pin_mask(addr_pin_mask), .port_state(port_state));
